// ===== hw/ifvpoc_pkg.sv
package ifvpoc_pkg;
    localparam int NFLOW      = 4;
    localparam int NCH        = 2;
    localparam int CH_W       = 1;
    localparam int HDR_BYTES  = 64;
    localparam int FIFO_DEPTH = 32;
    localparam int STREAM_W   = 10;
    localparam int FLOW_WORDS = 10;

    localparam logic [11:0] REG_GLOBAL      = 12'h000;
    localparam logic [11:0] REG_PTP_CTRL    = 12'h004;
    localparam logic [11:0] REG_STATUS      = 12'h008;
    localparam logic [11:0] REG_PTP_MASK_LO = 12'h00c;
    localparam logic [11:0] REG_PTP_MASK_HI = 12'h010;
    localparam logic [3:0]  REG_FLOW_PAGE   = 4'h1;
    localparam logic [3:0]  GLOBAL_LAST_WORD = 4'h4;
    localparam logic [3:0]  FW_CTRL       = 4'h0;
    localparam logic [3:0]  FW_MATCH0     = 4'h1;
    localparam logic [3:0]  FW_LAST       = 4'ha;
    localparam int          FS_MATCH      = 0;
    localparam int          FS_MASK       = 4;
    localparam int          FS_PTP_LO     = 8;
    localparam int          FS_PTP_HI     = 9;

    localparam int GC_MODE_LSB = 0;
    localparam int GC_PTR_LSB  = 8;
    localparam int GC_SIG_LSB  = 16;
    localparam int GC_KIND_LSB = 24;
    localparam int PC_PTR_LSB  = 0;
    localparam int FC_EN_BIT   = 0;
    localparam int FC_SEL_LSB  = 4;
    localparam int FC_CH_LSB   = 8;
    localparam int FC_ACT_LSB  = 16;
    localparam int ST_IP_LSB   = 0;
    localparam int ST_PTP_LSB  = 8;
    localparam int ST_TYPE_LSB = 16;
    localparam int ST_ACT_LSB  = 20;
    localparam int ST_SEEN_BIT = 31;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    localparam logic [1:0] MODE_IPV4   = 2'h0;
    localparam logic [1:0] MODE_IPV6   = 2'h1;
    localparam logic [1:0] MODE_OTH32  = 2'h2;
    localparam logic [1:0] MODE_OTH128 = 2'h3;
    localparam logic [1:0] SEL_SRC    = 2'h0;
    localparam logic [1:0] SEL_DST    = 2'h1;
    localparam logic [1:0] SEL_EITHER = 2'h2;
    localparam logic [5:0] IPV4_ADDR_BYTES = 6'h04;
    localparam logic [5:0] IPV6_ADDR_BYTES = 6'h10;

    localparam logic [1:0] KIND_PTP     = 2'h0;
    localparam logic [1:0] KIND_Y1731   = 2'h1;
    localparam logic [1:0] KIND_G8113   = 2'h2;
    localparam logic [1:0] KIND_RFC6374 = 2'h3;
    localparam logic [2:0] TYPE_NONE = 3'h0;
    localparam logic [2:0] TYPE_1DM  = 3'h1;
    localparam logic [2:0] TYPE_DMM  = 3'h2;
    localparam logic [2:0] TYPE_DMR  = 3'h3;
    localparam logic [2:0] TYPE_PTP  = 3'h4;
    localparam logic [7:0] OP_1DM    = 8'h2d;
    localparam logic [7:0] OP_DMM    = 8'h2f;
    localparam logic [7:0] OP_DMR    = 8'h2e;
    localparam logic [7:0] CC_QUERY  = 8'h00;
    localparam logic [7:0] CC_REPLY  = 8'h01;
    localparam logic [63:0] OAM_KEY_MASK = 64'hffff_ffff_0000_0000;

    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CAPT = 3'b010,
        ST_EVAL = 3'b100
    } ifvpoc_state_e;
endpackage : ifvpoc_pkg

// ===== hw/ifvpoc_stream_if.sv
`timescale 1ns/1ps
interface ifvpoc_stream_if #(parameter int W = 10) ();
    logic [W-1:0] data;
    logic         valid;
    logic         ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : ifvpoc_stream_if

// ===== hw/ifvpoc_fifo.sv
`timescale 1ns/1ps
module ifvpoc_fifo
    import ifvpoc_pkg::*;
#(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         ce,
    ifvpoc_stream_if.snk     push,
    ifvpoc_stream_if.src     pop
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wp_r;
    logic [AW:0]      rp_r;
    wire              full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire              empty = (wp_r == rp_r);
    wire              do_push = push.valid && push.ready;
    wire              do_pop  = pop.valid && pop.ready;

    // ready and valid carry ce so that no handshake completes while frozen
    assign push.ready = ce && !full;
    assign pop.valid  = ce && !empty;
    assign pop.data   = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r <= '0;
            rp_r <= '0;
        end else if (ce) begin
            if (do_push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (do_pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    // storage needs no reset; only written words are ever read
    always_ff @(posedge aclk) begin
        if (ce && do_push) begin
            mem_r[wp_r[AW-1:0]] <= push.data;
        end
    end
endmodule : ifvpoc_fifo

// ===== hw/ifvpoc_top.sv
`timescale 1ns/1ps
// How it works
// - a flow whose enable bit is clear never matches any frame
// - address select is used only in IPv4 or IPv6 modes, ignored otherwise
// - select 0 compares source, 1 destination, 2 accepts either address
// - match value is 128 bits; IPv4 compares only its upper 32 bits
// - each mask bit set within the compared width (upper 32 bits in 32-bit modes) makes its match bit count; clear bits are ignored
// - other protocols compare a 32 or 128 bit field at the pointer, no src/dst
// - a flow applies to a frame only if that frame's channel bit is set
// - a five-bit offset locates the field that builds the frame signature
// - the header-type stage is the final stage, handling PTP or OAM frames
// - PTP frames are not validated; only the first eight header bytes decide
// - leading header bytes compare to per-flow values; each flow owns its action
// - Y.1731 recognises exactly 1DM, DMM and DMR headers
// - Y.1731 frames are not validated; only the first four bytes decide
// - MPLS OAM handles G.8113.1 1DM/DMM/DMR and RFC6374 DMM/DMR
// - MPLS OAM frames are not validated; only the first four bytes decide
// - in IPv4/IPv6 the pointer marks the source address, else the match field
// - protocol select 0 IPv4, 1 IPv6, 2 other 32-bit, 3 other 128-bit
module ifvpoc_top
    import ifvpoc_pkg::*;
(
    input  wire  logic             aclk,
    input  wire  logic             aresetn,
    input  wire  logic             ce,
    input  wire  logic [11:0]      s_axi_awaddr,
    input  wire  logic [2:0]       s_axi_awprot,
    input  wire  logic             s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire  logic [31:0]      s_axi_wdata,
    input  wire  logic [3:0]       s_axi_wstrb,
    input  wire  logic             s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire  logic             s_axi_bready,
    input  wire  logic [11:0]      s_axi_araddr,
    input  wire  logic [2:0]       s_axi_arprot,
    input  wire  logic             s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire  logic             s_axi_rready,
    input  wire  logic [7:0]       in_data,
    input  wire  logic             in_sof,
    input  wire  logic             in_eof,
    input  wire  logic [CH_W-1:0]  in_channel,
    input  wire  logic             in_valid,
    output logic                   in_ready,
    output logic [7:0]             out_data,
    output logic                   out_sof,
    output logic                   out_eof,
    output logic                   out_valid,
    input  wire  logic             out_ready,
    output logic                   result_valid,
    output logic [NFLOW-1:0]       result_ip_hit,
    output logic [NFLOW-1:0]       result_ptp_hit,
    output logic [2:0]             result_type,
    output logic [3:0]             result_action,
    output logic [31:0]            result_signature
);
    // register decode
    // returns {valid, is_flow, flow[1:0], word[3:0]}
    function automatic logic [7:0] reg_decode(input logic [11:0] a);
        logic [3:0] w;
        logic       ok;
        w  = a[5:2];
        ok = 1'b0;
        if (a[11:8] == 4'h0 && a[7:6] == 2'h0) begin
            ok = (w <= GLOBAL_LAST_WORD);
            return {ok, 1'b0, 2'h0, w};
        end
        if (a[11:8] == REG_FLOW_PAGE) begin
            ok = (w <= FW_LAST);
        end
        return {ok, 1'b1, a[7:6], w};
    endfunction : reg_decode

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    logic [31:0]     gc_r;
    logic [31:0]     pc_r;
    logic [31:0]     pmask_lo_r;
    logic [31:0]     pmask_hi_r;
    logic [31:0]     fctl_r  [NFLOW];
    logic [31:0]     fword_r [NFLOW][FLOW_WORDS];
    logic            aw_have_r;
    logic [11:0]     aw_addr_r;
    logic            w_have_r;
    logic [31:0]     w_data_r;
    logic [3:0]      w_strb_r;
    logic            seen_r;

    wire  [7:0]      wdc    = reg_decode(aw_addr_r);
    wire  [7:0]      rdc    = reg_decode(s_axi_araddr);
    wire             wr_go  = aw_have_r && w_have_r && !s_axi_bvalid;
    wire             rd_go  = s_axi_arvalid && s_axi_arready;
    wire  [1:0]      wfl    = wdc[5:4];
    wire  [3:0]      wfi    = wdc[3:0] - FW_MATCH0;
    wire  [1:0]      rfl    = rdc[5:4];
    wire  [3:0]      rfi    = rdc[3:0] - FW_MATCH0;

    assign s_axi_awready = ce && !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready  = ce && !w_have_r && !s_axi_bvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;

    // configuration fields
    wire  [1:0]      mode     = gc_r[GC_MODE_LSB +: 2];
    wire  [4:0]      fptr     = gc_r[GC_PTR_LSB +: 5];
    wire  [4:0]      sig_off  = gc_r[GC_SIG_LSB +: 5];
    wire  [1:0]      kind     = gc_r[GC_KIND_LSB +: 2];
    wire  [5:0]      pptr     = pc_r[PC_PTR_LSB +: 6];
    wire  [63:0]     pmask    = {pmask_hi_r, pmask_lo_r};

    // frame capture
    ifvpoc_state_e   state_r;
    logic [6:0]      cnt_r;
    logic [CH_W-1:0] chan_r;
    logic [7:0]      hdr_r [HDR_BYTES];
    wire  [NFLOW-1:0] ip_hit;
    wire  [NFLOW-1:0] ptp_hit;
    logic [2:0]      htype;
    logic [3:0]      act;
    logic [127:0]    src_f;
    logic [127:0]    dst_f;
    logic [127:0]    key_f;
    logic [127:0]    sig_f;

    ifvpoc_stream_if #(.W(STREAM_W)) fin ();
    ifvpoc_stream_if #(.W(STREAM_W)) fout ();

    // one-cycle stall during evaluation keeps the next frame from overwriting the header
    wire             open_in = (state_r != ST_EVAL);
    wire             accept  = in_valid && in_ready;
    wire             cap_we  = accept && (in_sof || (state_r == ST_CAPT && cnt_r < 7'(HDR_BYTES)));
    wire  [5:0]      cap_idx = in_sof ? 6'h00 : cnt_r[5:0];

    assign fin.data  = {in_sof, in_eof, in_data};
    assign fin.valid = in_valid && open_in;
    assign in_ready  = fin.ready && open_in;
    assign out_valid = fout.valid;
    assign fout.ready = out_ready;
    assign {out_sof, out_eof, out_data} = fout.data;

    ifvpoc_fifo #(
        .WIDTH (STREAM_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .push    (fin),
        .pop     (fout)
    );

    for (genvar i = 0; i < HDR_BYTES; i++) begin : g_hdr
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                hdr_r[i] <= 8'h00;
            end else if (ce && cap_we && cap_idx == 6'(i)) begin
                hdr_r[i] <= in_data;
            end
        end
    end

    function automatic logic [127:0] field_at(input logic [5:0] start);
        logic [127:0] f;
        f = '0;
        for (int k = 0; k < 16; k++) begin
            f[127 - 8*k -: 8] = hdr_r[6'(start + 6'(k))];
        end
        return f;
    endfunction : field_at

    wire  [5:0]      dst_ptr = 6'(fptr) + ((mode == MODE_IPV4) ? IPV4_ADDR_BYTES : IPV6_ADDR_BYTES);
    wire             comparator_protocol_select = (mode == MODE_IPV4) || (mode == MODE_IPV6);
    wire             wide    = (mode == MODE_IPV6) || (mode == MODE_OTH128);

    always_comb begin
        src_f = field_at(6'(fptr));
        dst_f = field_at(dst_ptr);
        key_f = field_at(pptr);
        sig_f = field_at(6'(sig_off));
    end

    // header type (final stage)
    wire  [7:0]      op_byte = key_f[119:112];
    wire  [2:0]      oam_op  = (op_byte == OP_1DM) ? TYPE_1DM :
                               (op_byte == OP_DMM) ? TYPE_DMM :
                               (op_byte == OP_DMR) ? TYPE_DMR : TYPE_NONE;
    wire  [2:0]      rfc_op  = (op_byte == CC_QUERY) ? TYPE_DMM :
                               (op_byte == CC_REPLY) ? TYPE_DMR : TYPE_NONE;
    assign htype = (kind == KIND_PTP)     ? TYPE_PTP :
                   (kind == KIND_RFC6374) ? rfc_op : oam_op;
    // no validation of any header: PTP looks at eight bytes, OAM at four
    wire  [63:0]     key_mask = (kind == KIND_PTP) ? pmask : (pmask & OAM_KEY_MASK);

    // per-flow comparison
    for (genvar f = 0; f < NFLOW; f++) begin : g_flow
        wire [127:0] fm  = {fword_r[f][FS_MATCH+3], fword_r[f][FS_MATCH+2],
                            fword_r[f][FS_MATCH+1], fword_r[f][FS_MATCH]};
        wire [127:0] fk  = {fword_r[f][FS_MASK+3], fword_r[f][FS_MASK+2],
                            fword_r[f][FS_MASK+1], fword_r[f][FS_MASK]};
        wire [127:0] km  = wide ? fk : {fk[127:96], 96'h0};
        wire         sok = ((src_f ^ fm) & km) == '0;
        wire         dok = ((dst_f ^ fm) & km) == '0;
        wire [1:0]   sel = fctl_r[f][FC_SEL_LSB +: 2];
        wire         aok = (sel == SEL_SRC)    ? sok :
                           (sel == SEL_DST)    ? dok :
                           (sel == SEL_EITHER) ? (sok || dok) : 1'b0;
        wire         fok = comparator_protocol_select ? aok : sok;
        wire         en  = fctl_r[f][FC_EN_BIT];
        wire [NCH-1:0] chm = fctl_r[f][FC_CH_LSB +: NCH];
        wire         chok = chm[chan_r];
        wire [63:0]  pm  = {fword_r[f][FS_PTP_HI], fword_r[f][FS_PTP_LO]};
        wire         pok = ((key_f[127:64] ^ pm) & key_mask) == '0;
        assign ip_hit[f]  = en && chok && fok;
        assign ptp_hit[f] = en && chok && pok && (htype != TYPE_NONE);
    end

    // lowest-numbered flow hitting both stages supplies the action
    always_comb begin
        act = 4'h0;
        for (int f = NFLOW - 1; f >= 0; f--) begin
            if (ip_hit[f] && ptp_hit[f]) begin
                act = fctl_r[f][FC_ACT_LSB +: 4];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r          <= ST_IDLE;
            cnt_r            <= 7'h00;
            chan_r           <= '0;
            result_valid     <= 1'b0;
            result_ip_hit    <= '0;
            result_ptp_hit   <= '0;
            result_type      <= TYPE_NONE;
            result_action    <= 4'h0;
            result_signature <= 32'h0000_0000;
            seen_r           <= 1'b0;
        end else if (ce) begin
            result_valid <= 1'b0;
            if (cap_we) begin
                cnt_r <= in_sof ? 7'h01 : cnt_r + 7'h01;
            end
            if (accept && in_sof) begin
                chan_r <= in_channel;
            end
            case (state_r)
                ST_IDLE, ST_CAPT: begin
                    if (accept && in_eof && (in_sof || state_r == ST_CAPT)) begin
                        state_r <= ST_EVAL;
                    end else if (accept && in_sof) begin
                        state_r <= ST_CAPT;
                    end
                end
                ST_EVAL: begin
                    result_valid     <= 1'b1;
                    result_ip_hit    <= ip_hit;
                    result_ptp_hit   <= ptp_hit;
                    result_type      <= htype;
                    result_action    <= act;
                    result_signature <= sig_f[127:96];
                    seen_r           <= 1'b1;
                    state_r          <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // AXI4-Lite slave
    wire  [31:0]     status_w = (32'(result_ip_hit) << ST_IP_LSB) |
                                (32'(result_ptp_hit) << ST_PTP_LSB) |
                                (32'(result_type) << ST_TYPE_LSB) |
                                (32'(result_action) << ST_ACT_LSB) |
                                (32'(seen_r) << ST_SEEN_BIT);
    wire  [11:0]     rg_addr  = 12'({rdc[3:0], 2'b00});
    wire  [31:0]     rd_glob  = (rg_addr == REG_GLOBAL)      ? gc_r :
                                (rg_addr == REG_PTP_CTRL)    ? pc_r :
                                (rg_addr == REG_STATUS)      ? status_w :
                                (rg_addr == REG_PTP_MASK_LO) ? pmask_lo_r : pmask_hi_r;
    wire  [31:0]     rd_flow  = (rdc[3:0] == FW_CTRL) ? fctl_r[rfl] : fword_r[rfl][rfi];
    wire  [31:0]     rd_word  = !rdc[7] ? 32'h0000_0000 : (rdc[6] ? rd_flow : rd_glob);
    wire  [11:0]     wg_addr  = 12'({wdc[3:0], 2'b00});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r    <= 1'b0;
            aw_addr_r    <= 12'h000;
            w_have_r     <= 1'b0;
            w_data_r     <= 32'h0000_0000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= AXI_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= AXI_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wdc[7] ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rdc[7] ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // configuration store; writes to the status word are accepted and dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gc_r       <= RST_WORD;
            pc_r       <= RST_WORD;
            pmask_lo_r <= RST_WORD;
            pmask_hi_r <= RST_WORD;
            for (int f = 0; f < NFLOW; f++) begin
                fctl_r[f] <= RST_WORD;
                for (int k = 0; k < FLOW_WORDS; k++) begin
                    fword_r[f][k] <= RST_WORD;
                end
            end
        end else if (ce && wr_go && wdc[7]) begin
            if (wdc[6]) begin
                if (wdc[3:0] == FW_CTRL) begin
                    fctl_r[wfl] <= merge(fctl_r[wfl], w_data_r, w_strb_r);
                end else begin
                    fword_r[wfl][wfi] <= merge(fword_r[wfl][wfi], w_data_r, w_strb_r);
                end
            end else if (wg_addr == REG_GLOBAL) begin
                gc_r <= merge(gc_r, w_data_r, w_strb_r);
            end else if (wg_addr == REG_PTP_CTRL) begin
                pc_r <= merge(pc_r, w_data_r, w_strb_r);
            end else if (wg_addr == REG_PTP_MASK_LO) begin
                pmask_lo_r <= merge(pmask_lo_r, w_data_r, w_strb_r);
            end else if (wg_addr == REG_PTP_MASK_HI) begin
                pmask_hi_r <= merge(pmask_hi_r, w_data_r, w_strb_r);
            end
        end
    end
endmodule : ifvpoc_top

// ===== sim/ifvpoc_properties.sv
`timescale 1ns/1ps
module ifvpoc_properties
    import ifvpoc_pkg::*;
(
    input wire logic             aclk, aresetn, in_valid, in_ready, in_eof, result_valid,
    input wire logic             s_axi_awready, s_axi_wready, s_axi_bvalid,
    input wire logic             s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic [NFLOW-1:0] result_ip_hit, result_ptp_hit,
    input wire logic [3:0]       result_action,
    input wire logic [2:0]       result_type
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence eof_in; in_valid && in_ready && in_eof; endsequence
    sequence stall_res; !in_ready ##1 result_valid; endsequence
    a_result_latency: assert property (eof_in |=> stall_res) else $error("late result");
    a_result_pulse: assert property (result_valid |=> !result_valid) else $error("long pulse");
    a_no_type_hit: assert property (result_valid && result_type == TYPE_NONE |-> result_ptp_hit == 0)
        else $error("hit without type");
    a_action_idle: assert property (result_valid && !(|(result_ip_hit & result_ptp_hit))
        |-> result_action == 4'h0) else $error("action without hit");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw open");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
endmodule : ifvpoc_properties
bind ifvpoc_top ifvpoc_properties u_prop (.*);

// ===== sim/ifvpoc_src_model.sv
`timescale 1ns/1ps
module ifvpoc_src_model
    import ifvpoc_pkg::*;
(
    input wire logic        aclk, in_ready,
    output logic [7:0]      in_data = 8'h00,
    output logic            in_sof = 1'b0, in_eof = 1'b0, in_valid = 1'b0,
    output logic [CH_W-1:0] in_channel = '0
);
    logic [7:0] fr[64];
    task automatic send(input int n, input logic [CH_W-1:0] ch);
        for (int i = 0; i < n; i++) begin
            in_data <= fr[i];
            in_sof <= (i == 0);
            in_eof <= (i == n - 1);
            in_channel <= ch;
            in_valid <= 1'b1;
            do @(posedge aclk); while (in_ready !== 1'b1);
        end
        in_valid <= 1'b0;
        in_data <= ~fr[n - 1];
    endtask : send
endmodule : ifvpoc_src_model

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ifvpoc_pkg::*;
    logic aclk = 0, aresetn = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, out_ready = 0, hold = 0, ch;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_ready, in_sof;
    logic in_eof, in_valid, out_sof, out_eof, out_valid, result_valid;
    logic [CH_W-1:0] in_channel;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, p;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0, result_type;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, result_signature, a, b;
    logic [3:0] s_axi_wstrb = 4'hf, result_action;
    logic [1:0] s_axi_bresp, s_axi_rresp, md;
    logic [7:0] in_data, out_data;
    logic [NFLOW-1:0] result_ip_hit, result_ptp_hit;
    logic [31:0] fc[4] = '{32'h101, 32'h111, 32'h320, 32'h221};
    logic [31:0] fm[4] = '{32'h0a000001, 32'h0a000002, 32'h0a000001, 32'h0a000002};
    logic [31:0] fk[4] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffff00};
    logic [7:0] op[4] = '{OP_1DM, OP_DMM, OP_DMR, 8'h00};
    logic [2:0] ty[4] = '{TYPE_1DM, TYPE_DMM, TYPE_DMR, TYPE_NONE};
    int failures = 0, n_tests = 0, n_in = 0, n_out = 0, i, f, k;
    ifvpoc_top dut (.*);
    ifvpoc_src_model src (.*);
    always #20 aclk = ~aclk;
    always @(posedge aclk) begin
        out_ready <= hold ? 1'b0 : 1'($urandom % 2);
        n_in <= n_in + int'(in_valid && in_ready);
        n_out <= n_out + int'(out_valid && out_ready);
    end
    task automatic chk(input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] e);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        fork
            begin
                do @(posedge aclk); while (s_axi_awready !== 1'b1);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(posedge aclk); while (s_axi_wready !== 1'b1);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, e);
    endtask : wr
    task automatic rd(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] e);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, e);
    endtask : rd
    function automatic logic [3:0] exp_hit(input logic [31:0] s, d, input logic c, input logic [1:0] m);
        logic [3:0] e;
        logic hs, hd;
        for (int g = 0; g < 4; g++) begin
            hs = ((s ^ fm[g]) & fk[g]) == 0;
            hd = ((d ^ fm[g]) & fk[g]) == 0;
            e[g] = fc[g][0] & fc[g][8 + c] & (m != MODE_IPV4 ? hs : fc[g][5:4] == SEL_SRC ? hs
                : fc[g][5:4] == SEL_DST ? hd : fc[g][5:4] == SEL_EITHER & (hs | hd));
        end
        return e;
    endfunction : exp_hit
    task automatic frame(input int n, input logic c);
        src.send(n, c);
        for (int w = 0; w < 40 && result_valid !== 1'b1; w++) @(posedge aclk);
        chk(result_valid, 1'b1);
    endtask : frame
    initial begin
        void'($urandom(42));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(REG_GLOBAL, RST_WORD, AXI_OKAY);
        wr(12'h12c, 32'h1, AXI_SLVERR);
        rd(12'h12c, 32'h0, AXI_SLVERR);
        for (f = 0; f < 4; f++) begin
            p = 12'h100 + 12'(f * 64);
            wr(p, fc[f], AXI_OKAY);
            wr(p + 12'h10, fm[f], AXI_OKAY);
            wr(p + 12'h14, 32'hffffffff, AXI_OKAY);
            wr(p + 12'h20, fk[f], AXI_OKAY);
            rd(p, fc[f], AXI_OKAY);
        end
        for (k = 0; k < 32; k++) begin
            md = k < 16 ? MODE_IPV4 : 2'(k / 8);
            if (k % 8 == 0) wr(REG_GLOBAL, 32'(md), AXI_OKAY);
            a = fm[$urandom % 4] ^ (k[0] ? $urandom % 256 : 0);
            b = fm[$urandom % 4] ^ (k[1] ? $urandom : 0);
            ch = 1'($urandom % 2);
            {src.fr[0], src.fr[1], src.fr[2], src.fr[3]} = a;
            {src.fr[4], src.fr[5], src.fr[6], src.fr[7]} = b;
            frame(8, ch);
            chk(result_ip_hit, exp_hit(a, b, ch, md));
            chk(result_type, TYPE_PTP);
            chk(result_ptp_hit, ch ? 4'h8 : 4'h3);
            chk(result_signature, a);
        end
        hold <= 1'b1;
        fork
            frame(40, 1'b0);
            begin
                for (i = 0; i < 80 && in_ready !== 1'b0; i++) @(posedge aclk);
                chk(in_ready, 1'b0);
                hold <= 1'b0;
            end
        join
        wr(REG_PTP_CTRL, 32'h8, AXI_OKAY);
        for (k = 4; k < 16; k++) begin
            wr(REG_GLOBAL, 32'(k / 4) << GC_KIND_LSB, AXI_OKAY);
            for (i = 8; i < 12; i++) src.fr[i] = 8'($urandom);
            src.fr[9] = op[k % 4];
            frame(12, 1'b0);
            chk(result_type, k < 12 ? ty[k % 4] : k % 4 == 3 ? TYPE_DMM : TYPE_NONE);
        end
        repeat (100) @(posedge aclk);
        chk(n_out, n_in);
        test_done;
    end
    initial begin
        #400000;
        failures++;
        test_done;
    end
endmodule : tb_top
